/* core/src_cmd.sv */
// Speed reference command logic: contacts, ramps, fuel gating, input faults
//
// Contract
// - Dynamics input picks second dynamics set
// - Raise ramps reference up, capped at maximum
// - Raise released holds present reference
// - Lower ramps reference down, floored at minimum
// - Lower released holds present reference
// - Rated deselected disables raise and lower
// - Raise and lower together enable remote
// - Rated true ramps to rated over accel
// - Rated false ramps to idle over decel
// - Raise or lower cancels rated ramp
// - Remote uses remote rate, cancels accel
// - Run true lets speed loop govern fuel
// - Run false forces fuel to zero
// - Spares and remote flag low or high
// - Fuel limit input flags low only
// - Fault flags latch until reset and in range
// - Fuel demand clamped to external limit
// - Spare inputs expose value and alarms
// - Alarm reset acts briefly on first edge
`default_nettype none
module src_cmd #(
  parameter int SPD_W = src_pkg::SPD_W,
  parameter int ADC_W = src_pkg::ADC_W,
  parameter int FUEL_W = src_pkg::FUEL_W
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Field contacts
  input wire src_pkg::src_contacts_t CONTACTS,
  // Configuration
  input wire src_pkg::src_spd_cfg_t SPD_CFG,
  input wire src_pkg::src_thr_t THR_WIN,
  input wire logic [ADC_W-1:0] FLIM_LO_THR,
  input wire logic [1:0] SPARE_ALM_EN,
  // Analog samples from converters, and the speed loop fuel demand
  input wire logic [src_pkg::AIN_N*ADC_W-1:0] AIN,
  input wire logic [FUEL_W-1:0] FUEL_LOOP,
  // Speed reference results
  output logic [SPD_W-1:0] SPD_REF,
  output logic [1:0] RAMP_MODE,
  output logic REMOTE_EN,
  output logic DYN2_SEL,
  // Fuel results
  output logic [FUEL_W-1:0] FUEL_DEMAND,
  output logic LOOP_ACTIVE,
  // Analog input state
  output logic [src_pkg::AIN_N-1:0] AIN_FAIL,
  output logic [1:0] SPARE_ALARM,
  output logic [2*ADC_W-1:0] SPARE_VAL,
  output logic ALARM_RESET_PULSE
);
  // The carrier structs fix these widths, so the parameters may only
  // repeat the package values; anything else would misalign the fields
  if (SPD_W != src_pkg::SPD_W) begin : g_spd_w_chk
    $error("src_cmd: SPD_W must match the package");
  end
  if (ADC_W != src_pkg::ADC_W) begin : g_adc_w_chk
    $error("src_cmd: ADC_W must match the package");
  end
  // The fuel limit is left aligned, so the fuel word must be wider
  if (FUEL_W <= ADC_W) begin : g_fuel_w_chk
    $error("src_cmd: FUEL_W must exceed ADC_W");
  end
  // The remote sample is widened onto the speed range
  if (SPD_W < ADC_W) begin : g_rem_w_chk
    $error("src_cmd: SPD_W too narrow for the remote sample");
  end

  // Saturating step toward a target, never passing it
  function automatic logic [SPD_W-1:0] step_to(
    input logic [SPD_W-1:0] cur,
    input logic [SPD_W-1:0] tgt,
    input logic [SPD_W-1:0] stp
  );
    logic [SPD_W:0] sum;
    sum = {1'b0, cur} + {1'b0, stp};
    if (cur < tgt) begin
      step_to = (sum > {1'b0, tgt}) ? tgt : sum[SPD_W-1:0];
    end else if (cur > tgt) begin
      step_to = (cur - tgt < stp) ? tgt : cur - stp;
    end else begin
      step_to = cur;
    end
  endfunction

  src_pkg::src_contacts_t sync1_r;
  src_pkg::src_contacts_t sync2_r;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= CONTACTS;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      DYN2_SEL <= 1'b0;
    end else begin
      DYN2_SEL <= sync2_r.dyn2;
    end
  end

  logic ar_prev_r;
  logic ar_edge;
  logic [7:0] ar_cnt_r;
  // Only the rising edge counts, so a contact held closed acts once
  assign ar_edge = sync2_r.alarm_reset && !ar_prev_r;
  // Resets to the open-contact level, so no false edge after reset
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ar_prev_r <= 1'b0;
    end else begin
      ar_prev_r <= sync2_r.alarm_reset;
    end
  end

  // Window in which inputs good at the edge may clear their flags
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ar_cnt_r <= 8'h00;
    end else if (ar_edge) begin
      ar_cnt_r <= src_pkg::ALARM_PULSE_CYC;
    end else if (ar_cnt_r != 8'h00) begin
      ar_cnt_r <= ar_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ALARM_RESET_PULSE <= 1'b0;
    end else begin
      ALARM_RESET_PULSE <= ar_edge;
    end
  end

  // Analog window checks
  logic [src_pkg::AIN_N-1:0] bad;
  logic [ADC_W-1:0] smp [src_pkg::AIN_N];
  always_comb begin
    for (int i = 0; i < src_pkg::AIN_N; i++) begin
      smp[i] = AIN[i*ADC_W +: ADC_W];
    end
    for (int i = 0; i < src_pkg::AIN_FLIM; i++) begin
      bad[i] = (smp[i] < THR_WIN.lo_thr) || (smp[i] > THR_WIN.hi_thr);
    end
    bad[src_pkg::AIN_FLIM] = smp[src_pkg::AIN_FLIM] < FLIM_LO_THR;
  end

  // Set wins over the clear, and only good inputs clear on the edge
  logic [src_pkg::AIN_N-1:0] good_at_edge_r;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      good_at_edge_r <= '0;
    end else if (ar_edge) begin
      good_at_edge_r <= ~bad;
    end else if (ar_cnt_r == 8'h00) begin
      good_at_edge_r <= '0;
    end
  end

  // A live bad input re-sets its flag even inside the clear window
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      AIN_FAIL <= '0;
    end else begin
      AIN_FAIL <= bad | (AIN_FAIL & ~(good_at_edge_r & ~bad &
                  {src_pkg::AIN_N{ar_cnt_r != 8'h00}}));
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      SPARE_VAL <= '0;
    end else begin
      SPARE_VAL <= {smp[src_pkg::AIN_SPARE2], smp[src_pkg::AIN_SPARE1]};
    end
  end

  // Alarms follow the latched spare flags masked by SPARE_ALM_EN, one cycle behind them
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      SPARE_ALARM <= 2'b00;
    end else begin
      SPARE_ALARM <= AIN_FAIL[1:0] & SPARE_ALM_EN;
    end
  end

  // Mode selection
  logic rs;
  logic rl;
  logic both;
  src_pkg::src_mode_t mode_nxt;
  src_pkg::src_mode_t mode_r;
  assign rs = sync2_r.raise;
  assign rl = sync2_r.lower;
  assign both = rs && rl && sync2_r.rated;
  always_comb begin
    if (!sync2_r.rated) begin
      mode_nxt = src_pkg::SRC_RAMP_IDLE;
    end else if (both) begin
      mode_nxt = src_pkg::SRC_RAMP_REMOTE;
    end else if (rs || rl) begin
      mode_nxt = src_pkg::SRC_RAMP_MANUAL;
    end else if (mode_r == src_pkg::SRC_RAMP_IDLE) begin
      mode_nxt = src_pkg::SRC_RAMP_RATED;
    end else if (mode_r == src_pkg::SRC_RAMP_RATED) begin
      mode_nxt = src_pkg::SRC_RAMP_RATED;
    end else begin
      // Stay held after a manual or remote cancel
      mode_nxt = src_pkg::SRC_RAMP_MANUAL;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      mode_r <= src_pkg::SRC_RAMP_IDLE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // A separate copy keeps the output straight from a flip-flop
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      RAMP_MODE <= 2'b00;
    end else begin
      RAMP_MODE <= mode_nxt;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      REMOTE_EN <= 1'b0;
    end else begin
      REMOTE_EN <= both;
    end
  end

  // Remote target zero-extended from remote input, clamped to min and max speed
  logic [SPD_W-1:0] remote_tgt;
  always_comb begin
    remote_tgt = SPD_W'(smp[src_pkg::AIN_REMOTE]);
    if (remote_tgt > SPD_CFG.max_spd) begin
      remote_tgt = SPD_CFG.max_spd;
    end else if (remote_tgt < SPD_CFG.min_spd) begin
      remote_tgt = SPD_CFG.min_spd;
    end
  end

  // Reference ramp
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      SPD_REF <= src_pkg::SPD_RST;
    end else begin
      unique case (mode_nxt)
        src_pkg::SRC_RAMP_IDLE: begin
          SPD_REF <= step_to(SPD_REF, SPD_CFG.idle_spd, SPD_CFG.decel_step);
        end
        src_pkg::SRC_RAMP_RATED: begin
          SPD_REF <= step_to(SPD_REF, SPD_CFG.rated_spd, SPD_CFG.accel_step);
        end
        src_pkg::SRC_RAMP_MANUAL: begin
          if (rs) begin
            SPD_REF <= step_to(SPD_REF, SPD_CFG.max_spd, SPD_CFG.raise_step);
          end else if (rl) begin
            SPD_REF <= step_to(SPD_REF, SPD_CFG.min_spd, SPD_CFG.lower_step);
          end else begin
            SPD_REF <= SPD_REF;
          end
        end
        src_pkg::SRC_RAMP_REMOTE: begin
          SPD_REF <= step_to(SPD_REF, remote_tgt, SPD_CFG.remote_step);
        end
      endcase
    end
  end

  // Fuel limit scaled into fuel width, left aligned
  logic [FUEL_W-1:0] flim;
  assign flim = {smp[src_pkg::AIN_FLIM], {(FUEL_W-ADC_W){1'b0}}};

  // Shows whether the speed loop owns the fuel demand
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      LOOP_ACTIVE <= 1'b0;
    end else begin
      LOOP_ACTIVE <= sync2_r.run;
    end
  end

  // An open run contact wins over the loop without waiting for a ramp
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      FUEL_DEMAND <= '0;
    end else begin
      if (!sync2_r.run) begin
        FUEL_DEMAND <= '0;
      end else begin
        FUEL_DEMAND <= (FUEL_LOOP > flim) ? flim : FUEL_LOOP;
      end
    end
  end
endmodule
`default_nettype wire

/* core/src_pkg.sv */
// Package of constants and carrier types for the speed command logic
`default_nettype none
package src_pkg;
  localparam int SPD_W = 16;
  localparam int ADC_W = 12;
  localparam int FUEL_W = 16;
  // Analog input indices
  localparam int AIN_SPARE1 = 0;
  localparam int AIN_SPARE2 = 1;
  localparam int AIN_REMOTE = 2;
  localparam int AIN_FLIM = 3;
  localparam int AIN_N = 4;
  // Reset values and alarm reset window length
  localparam logic [15:0] SPD_RST = 16'h0000;
  localparam logic [7:0] ALARM_PULSE_CYC = 8'h10;
  localparam logic [ADC_W-1:0] ADC_ZERO = 12'h000;

  typedef enum logic [1:0] {
    SRC_RAMP_IDLE = 2'b00,
    SRC_RAMP_RATED = 2'b01,
    SRC_RAMP_MANUAL = 2'b11,
    SRC_RAMP_REMOTE = 2'b10
  } src_mode_t;

  // Discrete contact inputs, all from the field
  typedef struct packed {
    logic alarm_reset;
    logic dyn2;
    logic raise;
    logic lower;
    logic rated;
    logic run;
  } src_contacts_t;

  // Speed configuration set points
  typedef struct packed {
    logic [SPD_W-1:0] max_spd;
    logic [SPD_W-1:0] min_spd;
    logic [SPD_W-1:0] rated_spd;
    logic [SPD_W-1:0] idle_spd;
    logic [SPD_W-1:0] raise_step;
    logic [SPD_W-1:0] lower_step;
    logic [SPD_W-1:0] accel_step;
    logic [SPD_W-1:0] decel_step;
    logic [SPD_W-1:0] remote_step;
  } src_spd_cfg_t;

  // Window thresholds for the spare and remote analog inputs
  typedef struct packed {
    logic [ADC_W-1:0] lo_thr;
    logic [ADC_W-1:0] hi_thr;
  } src_thr_t;
endpackage
`default_nettype wire

/* tb/src_cmd_checker.sv */
// Assertion checker for the speed command logic ports
`default_nettype none
module src_cmd_checker (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Inputs watched
  input wire src_pkg::src_contacts_t CONTACTS,
  input wire src_pkg::src_spd_cfg_t SPD_CFG,
  input wire src_pkg::src_thr_t THR_WIN,
  input wire logic [11:0] FLIM_LO_THR,
  input wire logic [47:0] AIN,
  // Outputs watched
  input wire logic [15:0] SPD_REF,
  input wire logic [1:0] RAMP_MODE,
  input wire logic REMOTE_EN,
  input wire logic DYN2_SEL,
  input wire logic [15:0] FUEL_DEMAND,
  input wire logic LOOP_ACTIVE,
  input wire logic [3:0] AIN_FAIL,
  input wire logic ALARM_RESET_PULSE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_r;
  // Contacts need three clean edges before the outputs can follow them
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  property p_dyn;
    up_r == 2'h3 |-> DYN2_SEL == $past(CONTACTS.dyn2, 3);
  endproperty
  a_dyn: assert property (p_dyn)
    else $error("dynamics select wrong");
  property p_run;
    up_r == 2'h3 |-> LOOP_ACTIVE == $past(CONTACTS.run, 3);
  endproperty
  a_run: assert property (p_run)
    else $error("loop active wrong");
  property p_rem;
    up_r == 2'h3 |-> REMOTE_EN ==
      $past(CONTACTS.raise & CONTACTS.lower & CONTACTS.rated, 3);
  endproperty
  a_rem: assert property (p_rem)
    else $error("remote enable wrong");
  property p_man;
    up_r == 2'h3 && RAMP_MODE == 2'h3 |-> $past(CONTACTS.rated, 3);
  endproperty
  a_man: assert property (p_man)
    else $error("manual ramp without rated");
  property p_max;
    SPD_REF <= SPD_CFG.max_spd;
  endproperty
  a_max: assert property (p_max)
    else $error("reference above maximum");
  property p_stop;
    !LOOP_ACTIVE |-> FUEL_DEMAND == 16'h0000;
  endproperty
  a_stop: assert property (p_stop)
    else $error("fuel while stopped");
  property p_lim;
    LOOP_ACTIVE |-> FUEL_DEMAND <= {$past(AIN[47:36]), 4'h0};
  endproperty
  a_lim: assert property (p_lim)
    else $error("fuel above limit");
  property p_hi;
    $past(RSTN) && $past(AIN[11:0]) > $past(THR_WIN.hi_thr) |-> AIN_FAIL[0];
  endproperty
  a_hi: assert property (p_hi)
    else $error("high fault missed");
  property p_flim;
    $past(RSTN) && !$past(AIN_FAIL[3]) &&
      $past(AIN[47:36]) >= $past(FLIM_LO_THR) |-> !AIN_FAIL[3];
  endproperty
  a_flim: assert property (p_flim)
    else $error("fuel limit fault without low input");
  property p_pulse;
    ALARM_RESET_PULSE |-> $past(CONTACTS.alarm_reset, 3) &&
      !$past(CONTACTS.alarm_reset, 4) ##1 !ALARM_RESET_PULSE;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse wrong");
endmodule
bind src_cmd src_cmd_checker chk_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .CONTACTS(CONTACTS), .SPD_CFG(SPD_CFG), .THR_WIN(THR_WIN),
  .FLIM_LO_THR(FLIM_LO_THR), .AIN(AIN), .SPD_REF(SPD_REF),
  .RAMP_MODE(RAMP_MODE), .REMOTE_EN(REMOTE_EN), .DYN2_SEL(DYN2_SEL),
  .FUEL_DEMAND(FUEL_DEMAND), .LOOP_ACTIVE(LOOP_ACTIVE),
  .AIN_FAIL(AIN_FAIL), .ALARM_RESET_PULSE(ALARM_RESET_PULSE));
`default_nettype wire

/* tb/src_field.sv */
// Field side model: switch contacts and transmitters
`default_nettype none
module src_field (
  // Clock
  input wire logic clk,
  // Requested field state
  input wire src_pkg::src_contacts_t cmd,
  input wire logic [47:0] ain_cmd,
  // Lines into the control
  output var src_pkg::src_contacts_t contacts,
  output var logic [47:0] ain
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open contacts read false; closures land off the clock edge
  initial contacts = '0;
  always @(posedge clk) begin
    contacts <= #13 cmd;
  end
  always_comb begin
    ain = ain_cmd;
  end
endmodule
`default_nettype wire

/* tb/tb_speed_reference_command_logic.sv */
// Testbench for the speed reference command logic
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_speed_reference_command_logic;
  timeunit 1ns;
  timeprecision 1ns;
  localparam src_pkg::src_spd_cfg_t CFG = {16'h0100, 16'h0010, 16'h00c0,
    16'h0020, 16'h0004, 16'h0004, 16'h0008, 16'h0008, 16'h0002};
  localparam src_pkg::src_thr_t THR = {12'h100, 12'hf00};
  localparam logic [11:0] FLIM_LO = 12'h100;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  src_pkg::src_contacts_t cmd = '0;
  src_pkg::src_contacts_t contacts;
  logic [47:0] ain_cmd = {4{12'h800}};
  logic [47:0] ain;
  logic [47:0] a;
  logic [15:0] fuel_loop = 16'h1234;
  logic [1:0] alm_en = 2'h3;
  logic [15:0] spd_ref, fuel_demand, v;
  logic [1:0] ramp_mode, spare_alarm;
  logic remote_en, dyn2_sel, loop_active, pulse;
  logic [3:0] ain_fail;
  logic [23:0] spare_val;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rng = 32'd96819;
  always #50 clk_sys = ~clk_sys;
  src_field field_u (.clk(clk_sys), .cmd(cmd), .ain_cmd(ain_cmd),
    .contacts(contacts), .ain(ain));
  src_cmd dut_u (.CLK_SYS(clk_sys), .RSTN(rstn), .CONTACTS(contacts),
    .SPD_CFG(CFG), .THR_WIN(THR), .FLIM_LO_THR(FLIM_LO),
    .SPARE_ALM_EN(alm_en), .AIN(ain), .FUEL_LOOP(fuel_loop),
    .SPD_REF(spd_ref), .RAMP_MODE(ramp_mode), .REMOTE_EN(remote_en),
    .DYN2_SEL(dyn2_sel), .FUEL_DEMAND(fuel_demand),
    .LOOP_ACTIVE(loop_active), .AIN_FAIL(ain_fail),
    .SPARE_ALARM(spare_alarm), .SPARE_VAL(spare_val),
    .ALARM_RESET_PULSE(pulse));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [3:0] bad(input logic [47:0] x);
    for (int i = 0; i < 3; i++) begin
      bad[i] = x[i*12 +: 12] < THR.lo_thr || x[i*12 +: 12] > THR.hi_thr;
    end
    bad[3] = x[47:36] < FLIM_LO;
  endfunction
  task automatic put(input logic [5:0] c, input logic [47:0] x,
    input logic [15:0] f);
    @(posedge clk_sys);
    cmd <= c;
    ain_cmd <= x;
    fuel_loop <= f;
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Bounds the run so a stuck design still reaches the verdict
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    put(6'h13, {4{12'h800}}, 16'h1234);
    go(40);
    `CHK("rated", CFG.rated_spd, spd_ref)
    `CHK("dyn2", 1'b1, dyn2_sel)
    `CHK("fuel", 16'h1234, fuel_demand)
    put(6'h0b, {4{12'h800}}, 16'h1234);
    go(40);
    `CHK("max", CFG.max_spd, spd_ref)
    `CHK("manual", 2'h3, ramp_mode)
    put(6'h07, {4{12'h800}}, 16'h1234);
    go(10);
    put(6'h03, {4{12'h800}}, 16'h1234);
    go(4);
    v = spd_ref;
    go(10);
    `CHK("hold", v, spd_ref)
    put(6'h07, {4{12'h800}}, 16'h1234);
    go(80);
    `CHK("min", CFG.min_spd, spd_ref)
    put(6'h0f, {12'h800, 12'h080, 24'h800800}, 16'h1234);
    go(80);
    `CHK("remote en", 1'b1, remote_en)
    `CHK("remote", 16'h0080, spd_ref)
    put(6'h09, {12'h100, 36'h800800800}, 16'hffff);
    go(40);
    `CHK("idle mode", 2'h0, ramp_mode)
    `CHK("idle", CFG.idle_spd, spd_ref)
    `CHK("limit", 16'h1000, fuel_demand)
    put(6'h00, {12'h080, 24'h800800, 12'hfff}, 16'hffff);
    go(4);
    `CHK("stop", 16'h0000, fuel_demand)
    `CHK("faults", 4'hd, ain_fail)
    `CHK("spare alarm", 2'h1, spare_alarm)
    put(6'h00, {12'hfff, 36'h800800800}, 16'hffff);
    go(20);
    `CHK("latched", 4'hd, ain_fail)
    put(6'h20, {12'hfff, 36'h800800800}, 16'hffff);
    go(24);
    `CHK("cleared", 4'h0, ain_fail)
    repeat (300) begin
      rng = xs(rng);
      a[47:16] = rng;
      rng = xs(rng);
      a[15:0] = rng[15:0];
      put(rng[21:16], a, rng[29:14]);
      alm_en <= rng[31:30];
      go(1);
      `CHK("fail", bad(a), ain_fail & bad(a))
      `CHK("spare", a[23:0], spare_val)
    end
    close_out();
  end
endmodule
`undef CHK
`default_nettype wire
